// ===== hw/secondary_io_and_upstream_bar1.sv
// Notes on behaviour
// - IO window at 54h reads bit 0 as IO; base in bits 31:8 decodes accesses.
// - IO window always spans 256 bytes; only bits 31:8 writable and decoded.
// - Window-1 bits 2:1 give decode width, 00 32-bit, 01 64-bit; copied from setup bits 2:1.
// - Window-1 bit 3 reads 1 when prefetchable memory; taken from setup bit 3, always 0 for IO.
// - Window-1 size and space type follow the setup word at ECh.
// - Setup bit 31 low disables window 1; it claims nothing.
// - Window 1 covers 4KB to 2GB as memory, 64B to 2GB as IO.
// - Hits on window 1 forward with base replaced by translated base E8h.
// - Window-1 base bits 31:6 writable only where setup bit is one; reset zero.
`timescale 1ns/10ps
`include "bridge_bar_regs.svh"

module secondary_io_and_upstream_bar1 (
   input  wire logic        clk,            // Core clock, 25 MHz
   input  wire logic        srst,           // Synchronous reset, active high
   input  wire logic [7:0]  cfg_addr,       // Configuration byte offset
   input  wire logic [31:0] cfg_wdata,      // Configuration write data
   input  wire logic        cfg_wr,         // Write strobe
   input  wire logic        cfg_rd,         // Read strobe
   output logic      [31:0] cfg_rdata,      // Read data, cycle after strobe
   input  wire logic [31:0] win1_setup,     // Window-1 setup word
   input  wire logic [31:0] win1_xlat_base, // Window-1 translated base
   input  wire logic        io_req_valid,   // Secondary IO access present
   input  wire logic [31:0] io_req_addr,    // Secondary IO address
   output logic             ctrl_io_hit,    // IO access hits control window
   input  wire logic        up_req_valid,   // Upstream request present
   input  wire logic        up_req_is_io,   // Upstream request is IO
   input  wire logic [31:0] up_req_addr,    // Upstream request address
   output logic             win1_hit,       // Upstream request hits window 1
   output logic      [31:0] win1_fwd_addr   // Translated forwarding address
);

   ////////////////////////////////////////////////////////////////////////
   // Masked address comparison, shared by both windows
   function automatic logic masked_match(input logic [31:0] a,
                                         input logic [31:0] b,
                                         input logic [31:0] m);
      masked_match = ((a ^ b) & m) == 32'h00000000;
   endfunction

   // Register offset select, shared by both registers
   function automatic logic offset_is(input logic [7:0] a,
                                      input logic [7:0] ofs);
      offset_is = a == ofs;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Storage
   logic [`CTRL_IO_BASE_W-1:0] ctrl_io_base;
   logic [`WIN1_BASE_W-1:0]    win1_base;

   ////////////////////////////////////////////////////////////////////////
   // Window-1 configuration taken from the setup word
   wire                             win1_enable;
   wire bridge_bar_pkg::space_t     win1_space;
   wire bridge_bar_pkg::addr_type_t win1_atype;
   wire                             win1_pref;
   wire [`WIN1_BASE_W-1:0]          win1_size_limit;
   wire [`WIN1_BASE_W-1:0]          win1_wmask;
   wire [31:0]                      win1_amask;

   assign win1_enable = win1_setup[`SETUP_ENABLE_BIT];
   assign win1_space  = bridge_bar_pkg::space_t'(win1_setup[`WIN1_SPACE_BIT]);
   assign win1_atype  = win1_setup[`WIN1_ATYPE_HI:`WIN1_ATYPE_LO];
   assign win1_pref   = (win1_space == bridge_bar_pkg::SPACE_MEM)
                        & win1_setup[`WIN1_PREF_BIT];
   // Memory windows never go below 4KB; IO down to 64B
   assign win1_size_limit = (win1_space == bridge_bar_pkg::SPACE_MEM)
                            ? `WIN1_MEM_MIN_MASK : {`WIN1_BASE_W{1'b1}};
   assign win1_wmask = win1_setup[31:`WIN1_BASE_LSB] & win1_size_limit;
   assign win1_amask = {win1_wmask, {`WIN1_BASE_LSB{1'b0}}};

   ////////////////////////////////////////////////////////////////////////
   // Register decode and read-back values
   wire        sel_ctrl_io;
   wire        sel_win1;
   wire [31:0] ctrl_io_rd_word;
   wire [31:0] win1_rd_word;
   wire [31:0] next_cfg_rdata;

   assign sel_ctrl_io = offset_is(cfg_addr, `CTRL_IO_WINDOW_OFS);
   assign sel_win1    = offset_is(cfg_addr, `WIN1_BASE_OFS);
   // Reserved bits are constant zero
   assign ctrl_io_rd_word = {ctrl_io_base, 7'h00, `CTRL_IO_SPACE_RST};
   assign win1_rd_word    = {win1_base & win1_wmask, 2'h0, win1_pref,
                             win1_atype, win1_space};
   assign next_cfg_rdata  = !cfg_rd     ? `CFG_RDATA_IDLE :
                            sel_ctrl_io ? ctrl_io_rd_word :
                            sel_win1    ? win1_rd_word : `CFG_RDATA_IDLE;

   ////////////////////////////////////////////////////////////////////////
   // Write enables per register
   wire ctrl_io_wr;
   wire win1_wr;

   assign ctrl_io_wr = cfg_wr & sel_ctrl_io;
   assign win1_wr    = cfg_wr & sel_win1;

   ////////////////////////////////////////////////////////////////////////
   // Next base values, bit by bit
   wire [`CTRL_IO_BASE_W-1:0] next_ctrl_io_base;
   wire [`WIN1_BASE_W-1:0]    next_win1_base;

   generate
      for (genvar i = 0; i < `CTRL_IO_BASE_W; i++) begin : g_ctrl_io_bit
         // Every base bit writable; window stays at 256 bytes
         assign next_ctrl_io_base[i] = ctrl_io_wr ? cfg_wdata[`CTRL_IO_BASE_LSB + i]
                                                  : ctrl_io_base[i];
      end
      for (genvar j = 0; j < `WIN1_BASE_W; j++) begin : g_win1_bit
         // Writable only where the setup word grants it
         assign next_win1_base[j] = win1_wr ? (cfg_wdata[`WIN1_BASE_LSB + j] & win1_wmask[j])
                                            : win1_base[j];
      end
   endgenerate

   // Base registers
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_io_base <= `CTRL_IO_BASE_RST;
         win1_base    <= `WIN1_BASE_RST;
      end else begin
         ctrl_io_base <= next_ctrl_io_base;
         win1_base    <= next_win1_base;
      end
   end

   // Read data register
   always_ff @(posedge clk) begin
      if (srst)
         cfg_rdata <= `CFG_RDATA_IDLE;
      else
         cfg_rdata <= next_cfg_rdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode for both windows
   wire        next_ctrl_io_hit;
   wire        next_win1_hit;
   wire [31:0] next_win1_fwd_addr;
   wire [31:0] ctrl_io_amask;

   assign ctrl_io_amask    = {{`CTRL_IO_BASE_W{1'b1}}, 8'h00};
   assign next_ctrl_io_hit = io_req_valid
                             & masked_match(io_req_addr, ctrl_io_rd_word, ctrl_io_amask);
   assign next_win1_hit = up_req_valid & win1_enable
                          & (up_req_is_io == (win1_space == bridge_bar_pkg::SPACE_IO))
                          & masked_match(up_req_addr, {win1_base, 6'h00}, win1_amask);
   assign next_win1_fwd_addr = (up_req_addr & ~win1_amask)
                               | (win1_xlat_base & win1_amask);

   // Registered decode results
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_io_hit   <= 1'b0;
         win1_hit      <= 1'b0;
         win1_fwd_addr <= `WIN1_FWD_RST;
      end else begin
         ctrl_io_hit   <= next_ctrl_io_hit;
         win1_hit      <= next_win1_hit;
         win1_fwd_addr <= next_win1_fwd_addr;
      end
   end

endmodule

// ===== hw/bridge_bar_regs.svh
`ifndef BRIDGE_BAR_REGS_SVH
`define BRIDGE_BAR_REGS_SVH

// Register byte offsets in the configuration header
`define CTRL_IO_WINDOW_OFS  8'h54
`define WIN1_BASE_OFS       8'h58

// Control-register IO window layout
`define CTRL_IO_SPACE_BIT   0
`define CTRL_IO_BASE_LSB    8
`define CTRL_IO_BASE_W      24
`define CTRL_IO_SPACE_RST   1'b1
`define CTRL_IO_BASE_RST    24'h000000

// Window-1 register layout
`define WIN1_SPACE_BIT      0
`define WIN1_ATYPE_LO       1
`define WIN1_ATYPE_HI       2
`define WIN1_PREF_BIT       3
`define WIN1_BASE_LSB       6
`define WIN1_BASE_W         26
`define WIN1_BASE_RST       26'h0000000
`define WIN1_MEM_MIN_MASK   26'h3ffffc0

// Companion setup register layout
`define SETUP_ENABLE_BIT    31

// Read data for unmapped offsets
`define CFG_RDATA_IDLE      32'h00000000

// Forwarding address after reset
`define WIN1_FWD_RST        32'h00000000

`endif

// ===== hw/bridge_bar_pkg.sv
package bridge_bar_pkg;

   // Space indicator coding of a base register
   typedef enum logic {
      SPACE_MEM = 1'b0,
      SPACE_IO  = 1'b1
   } space_t;

   typedef logic [1:0] addr_type_t;

endpackage

// ===== dv/bar1_properties.sv
`timescale 1ns/10ps
module bar1_properties (
   input logic clk, srst, cfg_wr, cfg_rd, io_req_valid, ctrl_io_hit, up_req_valid, up_req_is_io, win1_hit,
   input logic [7:0]  cfg_addr,
   input logic [31:0] cfg_wdata, cfg_rdata, win1_setup, win1_xlat_base, io_req_addr, up_req_addr, win1_fwd_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Read of the window-1 register
   sequence rd58;
      cfg_rd && cfg_addr == 8'h58;
   endsequence
   AST_RD_IDLE: assert property (!cfg_rd |=> cfg_rdata == 32'h0) else $error("read data not idle");
   AST_IO_LOW: assert property (cfg_rd && cfg_addr == 8'h54 |=> cfg_rdata[7:0] == 8'h01)
      else $error("io window low byte wrong");
   AST_IO_MISS: assert property (!io_req_valid |=> !ctrl_io_hit) else $error("io hit without access");
   AST_W1_RSVD: assert property (rd58 |=> cfg_rdata[5:4] == 2'h0) else $error("reserved bits set");
   AST_W1_TYPE: assert property (rd58 |=> cfg_rdata[2:0] == $past(win1_setup[2:0]))
      else $error("type bits wrong");
   AST_W1_PREF: assert property (rd58 |=> cfg_rdata[3] == ($past(win1_setup[3]) & ~$past(win1_setup[0])))
      else $error("prefetch bit wrong");
   AST_W1_DIS: assert property (!win1_setup[31] |=> !win1_hit) else $error("hit while disabled");
   AST_W1_SPACE: assert property (up_req_valid && up_req_is_io != win1_setup[0] |=> !win1_hit)
      else $error("hit on wrong space");
   AST_W1_LOW: assert property (1'b1 |=> win1_fwd_addr[5:0] == $past(up_req_addr[5:0]))
      else $error("offset not kept");
endmodule
bind secondary_io_and_upstream_bar1 bar1_properties u_chk (.*);

// ===== dv/secondary_io_and_upstream_bar1_test.sv
`timescale 1ns/10ps
module secondary_io_and_upstream_bar1_test;
   logic clk = 0, srst = 1, cfg_wr = 0, cfg_rd = 0, io_req_valid = 0, up_req_valid = 0, up_req_is_io = 0;
   logic [7:0]  cfg_addr = 8'h00;
   logic [31:0] cfg_wdata = 0, win1_setup = 0, win1_xlat_base = 32'h12300000, io_req_addr = 0, up_req_addr = 0;
   logic [31:0] cfg_rdata, win1_fwd_addr;
   logic        ctrl_io_hit, win1_hit;
   int          failures = 0, n_compared = 0, cyc = 0;
   always #20 clk = ~clk;
   secondary_io_and_upstream_bar1 dut (
      .clk(clk), .srst(srst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .win1_setup(win1_setup), .win1_xlat_base(win1_xlat_base),
      .io_req_valid(io_req_valid), .io_req_addr(io_req_addr), .ctrl_io_hit(ctrl_io_hit),
      .up_req_valid(up_req_valid), .up_req_is_io(up_req_is_io), .up_req_addr(up_req_addr),
      .win1_hit(win1_hit), .win1_fwd_addr(win1_fwd_addr));
   ////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {cfg_wr, cfg_addr, cfg_wdata} <= {1'b1, a, d};
      @(posedge clk) cfg_wr <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk) {cfg_rd, cfg_addr} <= {1'b1, a};
      @(posedge clk) cfg_rd <= 0;
      #1 chk(cfg_rdata, e);
   endtask
   task up(input logic [31:0] a, input logic io, h, input logic [31:0] f);
      @(posedge clk) {up_req_valid, up_req_is_io, up_req_addr} <= {1'b1, io, a};
      @(posedge clk) up_req_valid <= 0;
      #1 chk({31'h0, win1_hit}, {31'h0, h});
      chk(win1_fwd_addr, f);
   endtask
   task iop(input logic [31:0] a, input logic h);
      @(posedge clk) {io_req_valid, io_req_addr} <= {1'b1, a};
      @(posedge clk) io_req_valid <= 0;
      #1 chk({31'h0, ctrl_io_hit}, {31'h0, h});
   endtask
   task report_and_stop;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         report_and_stop;
      end
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      srst <= 0;
      rd(8'h54, 32'h00000001);
      rd(8'h58, 32'h00000000);
      wr(8'h54, 32'hffffffff);
      rd(8'h54, 32'hffffff01);
      iop(32'hffffff80, 1);
      iop(32'hfffffe80, 0);
      @(posedge clk) win1_setup <= 32'hffffffca;
      wr(8'h58, 32'hffffffff);
      rd(8'h58, 32'hfffff00a);
      up(32'hfffff345, 0, 1, 32'h12300345);
      up(32'hfffff345, 1, 0, 32'h12300345);
      @(posedge clk) win1_setup <= 32'h7fffffca;
      rd(8'h58, 32'h7ffff00a);
      up(32'hfffff345, 0, 0, 32'h92300345);
      @(posedge clk) win1_setup <= 32'hffffffc1;
      wr(8'h58, 32'hffffffff);
      rd(8'h58, 32'hffffffc1);
      up(32'hffffffe5, 1, 1, 32'h12300025);
      wr(8'h5c, 32'hffffffff);
      rd(8'h5c, 32'h00000000);
      // Reset in mid-run clears both bases
      @(posedge clk) srst <= 1;
      repeat (2) @(posedge clk);
      srst <= 0;
      rd(8'h54, 32'h00000001);
      rd(8'h58, 32'h00000001);
      iop(32'h00000010, 1);
      report_and_stop;
   end
endmodule
